// ---- pkg/tmc_regs.svh ----
// Purpose: register map, field positions and reset values of the timer
//          control block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   per-half control fields repeat at TMC_CTL_B_SHIFT for half b
// How it works
// - in edge-count mode each half counts only rising, falling or both edges.
// - each half's pwm output is active high, or active low when inverted.
// - with the freeze bit set a half stops counting while the cpu is halted.
// - a half's trigger pulse leaves the block only while its enable is set.
// - with the wait bit set a half starts only after the preceding timeout.
// - each half has its own run enable, half a's ruling both when chained; clearing it stops that counter.
// - there are seven interrupt sources, three per half plus the rtc match.
// - each source has an enable; only enabled sources drive the irq line.
// - writing a clear mask drops the selected pending sources only.
// - raw and masked status are readable, masked being raw and enable.
// - the match value sets the match count in edge-count mode, duty in pwm.
// - two 16-bit halves run apart or chained as one 32-bit counter.
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

`define TMC_CFG_OFS      8'h00
`define TMC_CTL_OFS      8'h04
`define TMC_LOAD_A_OFS   8'h08
`define TMC_LOAD_B_OFS   8'h0c
`define TMC_MATCH_A_OFS  8'h10
`define TMC_MATCH_B_OFS  8'h14
`define TMC_VALUE_A_OFS  8'h18
`define TMC_VALUE_B_OFS  8'h1c
`define TMC_IMR_OFS      8'h20
`define TMC_RIS_OFS      8'h24
`define TMC_MIS_OFS      8'h28
`define TMC_ICR_OFS      8'h2c

// cfg: mode a [1:0], mode b [3:2], chain [4], rtc [5]
`define TMC_CFG_CHAIN    4
`define TMC_CFG_RTC      5
`define TMC_CFG_RST      6'h00

// ctl, per half: run, freeze, trigger, wait, invert, edge[6:5]
`define TMC_CTL_RUN      0
`define TMC_CTL_FREEZE   1
`define TMC_CTL_TRIG     2
`define TMC_CTL_WAIT     3
`define TMC_CTL_INV      4
`define TMC_CTL_EDGE     5
`define TMC_CTL_B_SHIFT  8
`define TMC_CTL_RST      16'h0000

// status bits: half a at 0..2, rtc at 3, half b at 4..6
`define TMC_IRQ_CAP_EVT  0
`define TMC_IRQ_CAP_MAT  1
`define TMC_IRQ_TIMEOUT  2
`define TMC_IRQ_RTC      3
`define TMC_IRQ_B_SHIFT  4
`define TMC_IRQ_RST      7'h00
`define TMC_HALF_RST     16'hffff

`endif

// ---- pkg/tmc_pkg.sv ----
// Purpose: types of the timer control block
// Assumes: nothing
// Notes:   codes count up from zero in declaration order and match the cfg and ctl fields
package tmc_pkg;
    typedef enum logic [1:0] {
        TMC_PERIODIC,
        TMC_ONE_SHOT,
        TMC_EDGE_COUNT,
        TMC_PWM
    } tmc_mode_t;

    typedef enum logic [1:0] {
        TMC_EDGE_RISE,
        TMC_EDGE_FALL,
        TMC_EDGE_RSVD,
        TMC_EDGE_BOTH
    } tmc_edge_t;
endpackage

// ---- src/tmc_edge_sync.sv ----
// Purpose: synchronise a capture pin and detect the selected edge
// Assumes: pin is asynchronous to pclk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module tmc_edge_sync (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pin,
    input  wire tmc_pkg::tmc_edge_t sel,
    output logic                  edge_pulse
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic change;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            s3_reg    <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign change = (s2_reg == s3_reg) && (s3_reg != level_reg);

    always_comb begin
        unique case (sel)
            tmc_pkg::TMC_EDGE_RISE: edge_pulse = change && s3_reg;
            tmc_pkg::TMC_EDGE_FALL: edge_pulse = change && !s3_reg;
            tmc_pkg::TMC_EDGE_BOTH: edge_pulse = change;
            default:                edge_pulse = 1'b0;
        endcase
    end
endmodule // tmc_edge_sync

// ---- src/tmc_half_cnt.sv ----
// Purpose: 16-bit down counter with reload for one timer half
// Assumes: dec and load come from pclk logic
// Notes:   wraps to the load value after zero
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_half_cnt (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic        dec,
    input  wire logic [15:0] load_val,
    output logic      [15:0] cnt_reg,
    output logic             zero
);
    assign zero = (cnt_reg == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= `TMC_HALF_RST;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (dec) begin
            cnt_reg <= zero ? load_val : cnt_reg - 16'h0001;
        end
    end
endmodule // tmc_half_cnt

// ---- src/tmc_timer_ctrl.sv ----
// Purpose: control and interrupt logic of a split/chained timer pair
// Assumes: debug_halted and chain_trigger_in are on pclk
// Notes:   zero-wait APB slave; unmapped access answers pslverr
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_timer_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        debug_halted,
    input  wire logic        chain_trigger_in,
    input  wire logic [1:0]  capture_in,
    output logic      [1:0]  pwm_out,
    output logic      [1:0]  pwm_oe,
    output logic      [1:0]  trigger_out,
    output logic             irq
);
    logic [5:0]  cfg_reg;
    logic [15:0] ctl_reg;
    logic [15:0] load_reg  [2];
    logic [15:0] match_reg [2];
    logic [15:0] cnt       [2];
    logic [6:0]  imr_reg;
    logic [6:0]  ris_reg;
    logic [6:0]  ris_next;
    logic [6:0]  irq_set;
    logic [31:0] rdata_next;
    logic        rd_ok;
    logic        wr_en;
    logic        setup;
    logic        chained;
    logic [1:0]  zero;
    logic [1:0]  edge_hit;
    logic [1:0]  dec;
    logic [1:0]  wrap;
    logic [1:0]  timeout;
    logic [1:0]  tick;
    logic [1:0]  load_now;
    logic [1:0]  start;
    logic [1:0]  started_reg;
    logic [1:0]  done_reg;
    logic [1:0]  cap_evt;
    logic [1:0]  cap_mat;
    logic [1:0]  pwm_reg;
    logic [1:0]  trig_reg;
    logic        rtc_hit;

    assign chained = cfg_reg[`TMC_CFG_CHAIN];
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `TMC_CFG_RST;
            ctl_reg <= `TMC_CTL_RST;
            imr_reg <= `TMC_IRQ_RST;
        end else if (wr_en) begin
            unique case (paddr)
                `TMC_CFG_OFS: cfg_reg <= pwdata[5:0];
                `TMC_CTL_OFS: ctl_reg <= pwdata[15:0];
                `TMC_IMR_OFS: imr_reg <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_reg[0]  <= `TMC_HALF_RST;
            load_reg[1]  <= `TMC_HALF_RST;
            match_reg[0] <= 16'h0000;
            match_reg[1] <= 16'h0000;
        end else if (wr_en) begin
            unique case (paddr)
                `TMC_LOAD_A_OFS:  load_reg[0]  <= pwdata[15:0];
                `TMC_LOAD_B_OFS:  load_reg[1]  <= pwdata[15:0];
                `TMC_MATCH_A_OFS: match_reg[0] <= pwdata[15:0];
                `TMC_MATCH_B_OFS: match_reg[1] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // per-half control and counting
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_half
            logic [7:0]         c;
            tmc_pkg::tmc_mode_t mode;
            logic               en;
            logic               chain_in;
            logic               frozen;

            // chained pair runs on the first half's controls
            assign c = (chained || i == 0) ? ctl_reg[7:0]
                                           : ctl_reg[15:8];
            assign mode = tmc_pkg::tmc_mode_t'(chained ? cfg_reg[1:0]
                                               : cfg_reg[2*i +: 2]);
            assign en = c[`TMC_CTL_RUN];
            // first half waits on the previous timer, second on the first
            assign chain_in = (i == 0) ? chain_trigger_in : timeout[0];
            assign frozen = c[`TMC_CTL_FREEZE] && debug_halted;
            assign start[i] = en && !started_reg[i]
                              && (!c[`TMC_CTL_WAIT] || chain_in);
            assign tick[i] = en && started_reg[i] && !done_reg[i]
                             && !frozen;
            assign load_now[i] = start[i] || (wr_en && paddr ==
                                 (i == 0 ? `TMC_LOAD_A_OFS
                                         : `TMC_LOAD_B_OFS));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    started_reg[i] <= 1'b0;
                end else if (!en) begin
                    started_reg[i] <= 1'b0;
                end else if (start[i]) begin
                    started_reg[i] <= 1'b1;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    done_reg[i] <= 1'b0;
                end else if (!en) begin
                    done_reg[i] <= 1'b0;
                end else if (timeout[i] && mode == tmc_pkg::TMC_ONE_SHOT) begin
                    done_reg[i] <= 1'b1;
                end
            end

            tmc_edge_sync u_edge (
                .pclk       (pclk),
                .presetn    (presetn),
                .pin        (capture_in[i]),
                .sel        (tmc_pkg::tmc_edge_t'(c[6:5])),
                .edge_pulse (edge_hit[i])
            );

            tmc_half_cnt u_cnt (
                .pclk     (pclk),
                .presetn  (presetn),
                .load     (load_now[i]),
                .dec      (dec[i]),
                .load_val (load_reg[i]),
                .cnt_reg  (cnt[i]),
                .zero     (zero[i])
            );

            assign wrap[i] = dec[i] && zero[i];
            // edge-count and pwm exist only for separate halves
            assign cap_evt[i] = !chained && tick[i] && edge_hit[i]
                                && mode == tmc_pkg::TMC_EDGE_COUNT;
            assign cap_mat[i] = cap_evt[i]
                                && cnt[i] == match_reg[i];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_reg[i] <= 1'b0;
                end else begin
                    // active while the count is above the match value
                    pwm_reg[i] <= (tick[i] && cnt[i] > match_reg[i])
                                  ^ c[`TMC_CTL_INV];
                end
            end
            assign pwm_out[i] = pwm_reg[i];
            assign pwm_oe[i]  = !chained && mode == tmc_pkg::TMC_PWM;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    trig_reg[i] <= 1'b0;
                end else begin
                    trig_reg[i] <= timeout[i] && c[`TMC_CTL_TRIG];
                end
            end
            assign trigger_out[i] = trig_reg[i];
        end
    endgenerate

    // upper half borrows from the lower half when chained
    assign dec[0] = (!chained && cfg_reg[1:0] == 2'(tmc_pkg::TMC_EDGE_COUNT))
                    ? cap_evt[0] : tick[0];
    assign dec[1] = chained ? (tick[0] && zero[0])
                  : (cfg_reg[3:2] == 2'(tmc_pkg::TMC_EDGE_COUNT))
                    ? cap_evt[1] : tick[1];
    assign timeout[0] = chained ? wrap[1] : wrap[0];
    assign timeout[1] = !chained && wrap[1];
    assign rtc_hit = chained && cfg_reg[`TMC_CFG_RTC] && tick[0]
                     && {cnt[1], cnt[0]} == {match_reg[1], match_reg[0]};

    // interrupt sources
    always_comb begin
        irq_set = 7'h00;
        irq_set[`TMC_IRQ_CAP_EVT] = cap_evt[0];
        irq_set[`TMC_IRQ_CAP_MAT] = cap_mat[0];
        irq_set[`TMC_IRQ_TIMEOUT] = timeout[0];
        irq_set[`TMC_IRQ_RTC]     = rtc_hit;
        irq_set[`TMC_IRQ_B_SHIFT + `TMC_IRQ_CAP_EVT] = cap_evt[1];
        irq_set[`TMC_IRQ_B_SHIFT + `TMC_IRQ_CAP_MAT] = cap_mat[1];
        irq_set[`TMC_IRQ_B_SHIFT + `TMC_IRQ_TIMEOUT] = timeout[1];
    end

    always_comb begin
        ris_next = ris_reg;
        if (wr_en && paddr == `TMC_ICR_OFS) begin
            ris_next = ris_reg & ~pwdata[6:0];
        end
        // a new event beats a clear in the same cycle
        ris_next = ris_next | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ris_reg <= `TMC_IRQ_RST;
        end else begin
            ris_reg <= ris_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ris_next & imr_reg);
        end
    end

    // read data prepared in the setup cycle
    always_comb begin
        rdata_next = 32'h0000_0000;
        rd_ok      = 1'b1;
        unique case (paddr)
            `TMC_CFG_OFS:     rdata_next[5:0]  = cfg_reg;
            `TMC_CTL_OFS:     rdata_next[15:0] = ctl_reg;
            `TMC_LOAD_A_OFS:  rdata_next[15:0] = load_reg[0];
            `TMC_LOAD_B_OFS:  rdata_next[15:0] = load_reg[1];
            `TMC_MATCH_A_OFS: rdata_next[15:0] = match_reg[0];
            `TMC_MATCH_B_OFS: rdata_next[15:0] = match_reg[1];
            `TMC_VALUE_A_OFS: rdata_next[15:0] = cnt[0];
            `TMC_VALUE_B_OFS: rdata_next[15:0] = cnt[1];
            `TMC_IMR_OFS:     rdata_next[6:0]  = imr_reg;
            `TMC_RIS_OFS:     rdata_next[6:0]  = ris_reg;
            `TMC_MIS_OFS:     rdata_next[6:0]  = ris_reg & imr_reg;
            `TMC_ICR_OFS:     rdata_next[6:0]  = 7'h00;
            default:          rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= !rd_ok;
        end
    end
endmodule // tmc_timer_ctrl

// ---- tb/tmc_timer_ctrl_assertions.sv ----
// Purpose: port-level checks of the timer control block
// Assumes: trigger load values above zero
// Notes:   sees ports only, so enables are inferred from apb traffic
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_timer_ctrl_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        debug_halted,
    input wire logic        chain_trigger_in,
    input wire logic [1:0]  capture_in,
    input wire logic [1:0]  pwm_out,
    input wire logic [1:0]  pwm_oe,
    input wire logic [1:0]  trigger_out,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    assign acc = psel && penable;
    assign rd  = acc && !pwrite;
    chk_irq_drop_write: assert property (
        $fell(irq) |-> $past(acc && pwrite)) else $error("irq fell alone");
    chk_clear_reads_zero: assert property (
        rd && paddr == `TMC_ICR_OFS |-> prdata == 32'h0)
        else $error("clear register read not zero");
    chk_status_seven_bits: assert property (
        rd && paddr inside {`TMC_RIS_OFS, `TMC_MIS_OFS, `TMC_IMR_OFS}
        |-> prdata[31:7] == 25'h0) else $error("status above bit 6");
    chk_pwm_oe_cfg: assert property (
        !$stable(pwm_oe) |-> $past(acc && pwrite && paddr == `TMC_CFG_OFS))
        else $error("pwm enable moved without cfg write");
    chk_reset_quiet: assert property (
        $rose(presetn) |-> !irq && trigger_out == 2'h0 && pwm_out == 2'h0)
        else $error("outputs active after reset");
    chk_unmapped_err: assert property (
        acc && paddr > `TMC_ICR_OFS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (
        acc && paddr <= `TMC_ICR_OFS && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    chk_trig_one_cycle: assert property (
        trigger_out[0] |=> !trigger_out[0]) else $error("trigger held");
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (trigger_out[0]);
    cover property (acc && pslverr);
endmodule // tmc_timer_ctrl_assertions
bind tmc_timer_ctrl tmc_timer_ctrl_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_halted(debug_halted),
    .chain_trigger_in(chain_trigger_in), .capture_in(capture_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .trigger_out(trigger_out),
    .irq(irq));

// ---- tb/tmc_far_model.sv ----
// Purpose: capture pins and preceding timer of the chain
// Assumes: bench sets pin levels and chain requests
// Notes:   pins change just after an edge, as a real pin might not
`timescale 1ns/1ps
module tmc_far_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] pin_level,
    input  wire logic       chain_go,
    output logic      [1:0] capture_in,
    output logic            chain_trigger_in
);
    logic go_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_in <= 2'h0;
        end else begin
            capture_in <= pin_level;
        end
    end
    // one timeout pulse per request, like a preceding timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q             <= 1'b0;
            chain_trigger_in <= 1'b0;
        end else begin
            go_q             <= chain_go;
            chain_trigger_in <= chain_go && !go_q;
        end
    end
endmodule // tmc_far_model

// ---- tb/testbench.sv ----
// Purpose: apb-driven test of the timer control block
// Assumes: zero-wait slave, timing as handed over
// Notes:   pwm duty checked by complement, not by exact phase
`timescale 1ns/1ps
`include "tmc_regs.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    error_cnt++; $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        debug_halted = 1'b0;
    logic [1:0]  pin_level = 2'h0;
    logic        chain_go = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        chain_trigger_in;
    logic [1:0]  capture_in;
    logic [1:0]  pwm_out;
    logic [1:0]  pwm_oe;
    logic [1:0]  trigger_out;
    logic        irq;
    logic [31:0] rdat;
    logic [31:0] v;
    logic        rerr;
    logic [1:0]  esel [3] = '{2'h0, 2'h1, 2'h3};
    int          dec [3] = '{2, 1, 3};
    logic        mexp [3] = '{1'b1, 1'b0, 1'b1};
    int          error_cnt = 0;
    int          comparisons = 0;
    int          seen;
    int          bad;
    int          h [2];
    always #5 pclk = ~pclk;
    tmc_timer_ctrl u_tmc_timer_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_halted(debug_halted),
        .chain_trigger_in(chain_trigger_in), .capture_in(capture_in),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .trigger_out(trigger_out),
        .irq(irq));
    tmc_far_model u_tmc_far_model (
        .pclk(pclk), .presetn(presetn), .pin_level(pin_level),
        .chain_go(chain_go), .capture_in(capture_in),
        .chain_trigger_in(chain_trigger_in));
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, rdat)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic pin(input logic [1:0] l);
        pin_level <= l;
        tick(8);
    endtask
    task test_done;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #300us;
        error_cnt++;
        test_done();
    end
    initial begin
        tick(20);
        presetn <= 1'b1;
        rd(`TMC_CFG_OFS, 32'h0, "cfg");
        rd(`TMC_CTL_OFS, 32'h0, "ctl");
        rd(`TMC_IMR_OFS, 32'h0, "imr");
        rd(`TMC_RIS_OFS, 32'h0, "ris");
        rd(`TMC_VALUE_A_OFS, 32'hffff, "value_a");
        rd(8'h40, 32'h0, "unmapped");
        `CHK("pslverr", 1'b1, rerr)
        wr(`TMC_LOAD_A_OFS, 32'h3);
        wr(`TMC_LOAD_B_OFS, 32'h3);
        wr(`TMC_CTL_OFS, 32'h0105);
        seen = 0;
        bad = 0;
        repeat (30) begin
            @(posedge pclk);
            #1;
            seen += (trigger_out[0] === 1'b1);
            bad += (trigger_out[1] !== 1'b0);
        end
        `CHK("trig_a", 1'b1, seen > 0)
        `CHK("trig_b_off", 0, bad)
        wr(`TMC_CTL_OFS, 32'h0);
        xfer(1'b0, `TMC_VALUE_A_OFS, 32'h0);
        v = rdat;
        tick(10);
        rd(`TMC_VALUE_A_OFS, v, "stopped");
        rd(`TMC_RIS_OFS, 32'h44, "ris_both");
        rd(`TMC_MIS_OFS, 32'h0, "mis_off");
        `CHK("irq_off", 1'b0, irq)
        wr(`TMC_IMR_OFS, 32'h04);
        rd(`TMC_MIS_OFS, 32'h04, "mis_on");
        `CHK("irq_on", 1'b1, irq)
        wr(`TMC_ICR_OFS, 32'h04);
        rd(`TMC_RIS_OFS, 32'h40, "ris_clr");
        `CHK("irq_clr", 1'b0, irq)
        wr(`TMC_ICR_OFS, 32'h7f);
        wr(`TMC_IMR_OFS, 32'h0);
        wr(`TMC_CTL_OFS, 32'h09);
        tick(20);
        rd(`TMC_RIS_OFS, 32'h0, "ris_wait");
        chain_go <= 1'b1;
        tick(20);
        rd(`TMC_RIS_OFS, 32'h04, "ris_chain");
        chain_go <= 1'b0;
        debug_halted <= 1'b1;
        wr(`TMC_CTL_OFS, 32'h03);
        wr(`TMC_ICR_OFS, 32'h7f);
        tick(20);
        rd(`TMC_RIS_OFS, 32'h0, "ris_freeze");
        wr(`TMC_CTL_OFS, 32'h01);
        tick(20);
        rd(`TMC_RIS_OFS, 32'h04, "ris_nofreeze");
        debug_halted <= 1'b0;
        wr(`TMC_CTL_OFS, 32'h0);
        wr(`TMC_CFG_OFS, 32'h2);
        wr(`TMC_LOAD_A_OFS, 32'h100);
        wr(`TMC_MATCH_A_OFS, 32'hff);
        for (int i = 0; i < 3; i++) begin
            wr(`TMC_ICR_OFS, 32'h7f);
            wr(`TMC_CTL_OFS, {25'h0, esel[i], 5'h01});
            tick(8);
            pin(2'h1);
            pin(2'h0);
            pin(2'h1);
            rd(`TMC_VALUE_A_OFS, 32'h100 - dec[i], "edges");
            xfer(1'b0, `TMC_RIS_OFS, 32'h0);
            `CHK("match", mexp[i], rdat[1])
            wr(`TMC_CTL_OFS, 32'h0);
            pin(2'h0);
        end
        wr(`TMC_CFG_OFS, 32'h3);
        wr(`TMC_LOAD_A_OFS, 32'h8);
        wr(`TMC_MATCH_A_OFS, 32'h4);
        for (int i = 0; i < 2; i++) begin
            wr(`TMC_CTL_OFS, i ? 32'h11 : 32'h01);
            h[i] = 0;
            repeat (18) begin
                @(posedge pclk);
                #1;
                h[i] += (pwm_out[0] === 1'b1);
            end
            `CHK("pwm_oe", 2'h1, pwm_oe)
            wr(`TMC_CTL_OFS, 32'h0);
        end
        `CHK("pwm_inv", 18 - h[0], h[1])
        `CHK("pwm_duty", 1'b1, h[0] > 0 && h[0] < 18)
        test_done();
    end
endmodule // testbench
